//--- lkidx_params.svh
// offsets, field positions, reset values and limits of the lookup index and unknown-forward block
`ifndef LKIDX_PARAMS_SVH
`define LKIDX_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LKIDX_AW              12
`define LKIDX_OFF_INT_STATUS  12'h314
`define LKIDX_OFF_INT_MASK    12'h315
`define LKIDX_OFF_IDX0        12'h316
`define LKIDX_OFF_IDX1        12'h318
`define LKIDX_OFF_IDX2        12'h31A
`define LKIDX_OFF_FWD_UC      12'h320
`define LKIDX_OFF_FWD_MC      12'h324
`define LKIDX_OFF_FWD_VID     12'h328

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LKIDX_FLAG_LEARN      2
`define LKIDX_FLAG_ALMOST     1
`define LKIDX_FLAG_WRFAIL     0
`define LKIDX_FWD_EN_BIT      7
`define LKIDX_FWD_P5_BIT      6

// ----------------------------------------------------------------
// reset values and bucket occupancy limits
// ----------------------------------------------------------------
`define LKIDX_MASK_RESET      3'h7
`define LKIDX_FLAG_RESET      3'h0
`define LKIDX_IDX_RESET       12'h000
`define LKIDX_ALMOST_LO       3'h2
`define LKIDX_ALMOST_HI       3'h3
`define LKIDX_BUCKET_FULL     3'h4

`endif

//--- lkidx_pkg.sv
// types shared by the lookup index and unknown-forward block
`default_nettype none
package lkidx_pkg;

  // forwarding category picked for one packet
  typedef enum logic [1:0] {
    LKIDX_CAT_NONE = 2'b00,
    LKIDX_CAT_VID  = 2'b01,
    LKIDX_CAT_UC   = 2'b10,
    LKIDX_CAT_MC   = 2'b11
  } lkidx_cat_t;

  // destination ports 1..5 in bits 0..4
  typedef logic [4:0] lkidx_port_map_t;

endpackage : lkidx_pkg
`default_nettype wire

//--- lkidx_fwd_ctrl.sv
// one unknown-forward control register: enable bit and five-port destination map
`default_nettype none
`include "lkidx_params.svh"
module lkidx_fwd_ctrl #(
  parameter logic [`LKIDX_AW-1:0] BASE = `LKIDX_OFF_FWD_UC
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // register write port
  input  wire logic                    reg_wr,
  input  wire logic [`LKIDX_AW-1:0]    reg_addr,
  input  wire logic [7:0]              reg_wdata,
  // control state
  output logic      [31:0]             ctrl_word,
  output logic                         fwd_en,
  output lkidx_pkg::lkidx_port_map_t   port_map
);
  import lkidx_pkg::*;

  // ----------------------------------------------------------------
  // byte writes, most significant byte at the base offset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fwd_en <= 1'b0;
    end else if (reg_wr && reg_addr == BASE) begin
      fwd_en <= reg_wdata[`LKIDX_FWD_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_map <= 5'h00;
    end else if (reg_wr && reg_addr == BASE + 12'h003) begin
      // ports 1..4 from bits 3:0, port 5 from bit 6; bits 5:4 reserved
      port_map <= {reg_wdata[`LKIDX_FWD_P5_BIT], reg_wdata[3:0]};
    end
  end

  // reserved bits read as zero
  assign ctrl_word = {fwd_en, 24'h000000, port_map[4], 2'b00, port_map[3:0]};

endmodule : lkidx_fwd_ctrl
`default_nettype wire

//--- lkidx_lookup_status.sv
// lookup table index capture, interrupt flags and unknown-packet forwarding controls
//
// Operation
// - successful static write into bucket holding two or three statics captures entry address
// - failed static write captures the target bucket address in index register zero
// - learn failure on a bucket of four statics captures that bucket address
// - every host read or write of the table captures the accessed bucket
// - one category per packet: unknown VLAN, then unicast, then multicast
// - unicast control bit 31 enables special forwarding of unknown unicast packets
// - unicast control bits 0-3 pick ports 1-4, bit 6 picks port 5
// - multicast control bit 31 enables special forwarding of unknown multicast packets
// - multicast control bits 0-3 pick ports 1-4, bit 6 picks port 5
// - VLAN control bit 31 enables special forwarding of unknown VLAN packets
// - VLAN control bits 0-3 pick ports 1-4, bit 6 picks port 5
// - each capture except host access sets its write-one-to-clear flag; all flags masked after reset
`default_nettype none
`include "lkidx_params.svh"
module lkidx_lookup_status (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // management register port, byte wide
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [`LKIDX_AW-1:0]    reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  output logic                         reg_rvalid,
  // lookup engine events
  input  wire logic                    ev_static_wr_ok,
  input  wire logic [2:0]              ev_static_prior_cnt,
  input  wire logic [11:0]             ev_entry_addr,
  input  wire logic                    ev_static_wr_fail,
  input  wire logic [9:0]              ev_fail_bucket,
  input  wire logic                    ev_learn_fail,
  input  wire logic [2:0]              ev_learn_static_cnt,
  input  wire logic [9:0]              ev_learn_bucket,
  input  wire logic                    ev_host_access,
  input  wire logic [9:0]              ev_host_bucket,
  // packet classification
  input  wire logic                    pkt_valid,
  input  wire logic                    pkt_unknown_vid,
  input  wire logic                    pkt_unknown_uc,
  input  wire logic                    pkt_unknown_mc,
  // forwarding decision
  output logic                         fwd_valid,
  output logic                         fwd_special,
  output lkidx_pkg::lkidx_port_map_t   fwd_port_map,
  output lkidx_pkg::lkidx_cat_t        fwd_category,
  // unmasked flag summary
  output logic                         lue_int
);
  import lkidx_pkg::*;

  // ----------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------
  logic        almost_full_hit;
  logic        learn_fail_hit;
  logic [11:0] idx0;
  logic [9:0]  idx1;
  logic [9:0]  idx2;
  logic [2:0]  int_flags;
  logic [2:0]  int_mask;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;

  assign almost_full_hit = ev_static_wr_ok &&
                           (ev_static_prior_cnt == `LKIDX_ALMOST_LO ||
                            ev_static_prior_cnt == `LKIDX_ALMOST_HI);
  assign learn_fail_hit  = ev_learn_fail &&
                           ev_learn_static_cnt == `LKIDX_BUCKET_FULL;

  // ----------------------------------------------------------------
  // index captures
  // ----------------------------------------------------------------
  // almost-full and write-fail share one field; both come from the same
  // write so they never coincide, but a failure wins if they do
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      idx0 <= `LKIDX_IDX_RESET;
    end else if (ev_static_wr_fail) begin
      idx0 <= {2'b00, ev_fail_bucket};
    end else if (almost_full_hit) begin
      idx0 <= ev_entry_addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      idx1 <= 10'h000;
    end else if (learn_fail_hit) begin
      idx1 <= ev_learn_bucket;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      idx2 <= 10'h000;
    end else if (ev_host_access) begin
      idx2 <= ev_host_bucket;
    end
  end

  // ----------------------------------------------------------------
  // status flags and mask
  // ----------------------------------------------------------------
  always_comb begin
    flag_set                     = 3'h0;
    flag_set[`LKIDX_FLAG_LEARN]  = learn_fail_hit;
    flag_set[`LKIDX_FLAG_ALMOST] = almost_full_hit;
    flag_set[`LKIDX_FLAG_WRFAIL] = ev_static_wr_fail;
  end

  assign flag_clr = (reg_wr && reg_addr == `LKIDX_OFF_INT_STATUS) ? reg_wdata[2:0] : 3'h0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_flags <= `LKIDX_FLAG_RESET;
    end else begin
      int_flags <= (int_flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_mask <= `LKIDX_MASK_RESET;
    end else if (reg_wr && reg_addr == `LKIDX_OFF_INT_MASK) begin
      int_mask <= reg_wdata[2:0];
    end
  end

  // mask bit set means that flag is kept off the summary
  assign lue_int = |(int_flags & ~int_mask);

  // ----------------------------------------------------------------
  // forwarding controls: 0 unicast, 1 multicast, 2 unknown VLAN
  // ----------------------------------------------------------------
  logic [31:0]     fwd_word [3];
  logic            fwd_en   [3];
  lkidx_port_map_t fwd_map  [3];

  for (genvar g = 0; g < 3; g++) begin : g_fwd
    localparam logic [`LKIDX_AW-1:0] BASE = (g == 0) ? `LKIDX_OFF_FWD_UC :
                                            (g == 1) ? `LKIDX_OFF_FWD_MC :
                                                       `LKIDX_OFF_FWD_VID;
    lkidx_fwd_ctrl #(
      .BASE (BASE)
    ) u_ctrl (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .reg_wr    (reg_wr),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .ctrl_word (fwd_word[g]),
      .fwd_en    (fwd_en[g]),
      .port_map  (fwd_map[g])
    );
  end

  // ----------------------------------------------------------------
  // category resolution
  // ----------------------------------------------------------------
  lkidx_cat_t      next_category;
  logic            next_special;
  lkidx_port_map_t next_map;

  // the category is fixed before its enable is looked at: a disabled
  // winner never falls through to a lower category
  always_comb begin
    if (pkt_unknown_vid) begin
      next_category = LKIDX_CAT_VID;
    end else if (pkt_unknown_uc) begin
      next_category = LKIDX_CAT_UC;
    end else if (pkt_unknown_mc) begin
      next_category = LKIDX_CAT_MC;
    end else begin
      next_category = LKIDX_CAT_NONE;
    end
  end

  always_comb begin
    case (next_category)
      LKIDX_CAT_VID: begin
        next_special = fwd_en[2];
        next_map     = fwd_map[2];
      end
      LKIDX_CAT_UC: begin
        next_special = fwd_en[0];
        next_map     = fwd_map[0];
      end
      LKIDX_CAT_MC: begin
        next_special = fwd_en[1];
        next_map     = fwd_map[1];
      end
      default: begin
        next_special = 1'b0;
        next_map     = 5'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fwd_valid    <= 1'b0;
      fwd_special  <= 1'b0;
      fwd_port_map <= 5'h00;
      fwd_category <= LKIDX_CAT_NONE;
    end else begin
      fwd_valid    <= pkt_valid;
      fwd_special  <= pkt_valid && next_special;
      fwd_port_map <= (pkt_valid && next_special) ? next_map : 5'h00;
      fwd_category <= pkt_valid ? next_category : LKIDX_CAT_NONE;
    end
  end

  // ----------------------------------------------------------------
  // register read, one cycle latency, big-endian byte order
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    case (reg_addr)
      `LKIDX_OFF_INT_STATUS:     next_rdata = {5'h00, int_flags};
      `LKIDX_OFF_INT_MASK:       next_rdata = {5'h00, int_mask};
      `LKIDX_OFF_IDX0:           next_rdata = {4'h0, idx0[11:8]};
      `LKIDX_OFF_IDX0 + 12'h001: next_rdata = idx0[7:0];
      `LKIDX_OFF_IDX1:           next_rdata = {6'h00, idx1[9:8]};
      `LKIDX_OFF_IDX1 + 12'h001: next_rdata = idx1[7:0];
      `LKIDX_OFF_IDX2:           next_rdata = {6'h00, idx2[9:8]};
      `LKIDX_OFF_IDX2 + 12'h001: next_rdata = idx2[7:0];
      `LKIDX_OFF_FWD_UC:         next_rdata = fwd_word[0][31:24];
      `LKIDX_OFF_FWD_UC + 12'h001: next_rdata = fwd_word[0][23:16];
      `LKIDX_OFF_FWD_UC + 12'h002: next_rdata = fwd_word[0][15:8];
      `LKIDX_OFF_FWD_UC + 12'h003: next_rdata = fwd_word[0][7:0];
      `LKIDX_OFF_FWD_MC:         next_rdata = fwd_word[1][31:24];
      `LKIDX_OFF_FWD_MC + 12'h001: next_rdata = fwd_word[1][23:16];
      `LKIDX_OFF_FWD_MC + 12'h002: next_rdata = fwd_word[1][15:8];
      `LKIDX_OFF_FWD_MC + 12'h003: next_rdata = fwd_word[1][7:0];
      `LKIDX_OFF_FWD_VID:        next_rdata = fwd_word[2][31:24];
      `LKIDX_OFF_FWD_VID + 12'h001: next_rdata = fwd_word[2][23:16];
      `LKIDX_OFF_FWD_VID + 12'h002: next_rdata = fwd_word[2][15:8];
      `LKIDX_OFF_FWD_VID + 12'h003: next_rdata = fwd_word[2][7:0];
      // unmapped bytes read as zero
      default:                   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule : lkidx_lookup_status
`default_nettype wire

//--- lkidx_lookup_status_sva.sv
// assertions on the lookup index and unknown-forward block
`default_nettype none
`include "lkidx_params.svh"
module lkidx_lookup_status_sva (
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  // register port
  input wire logic                  reg_rd,
  input wire logic [`LKIDX_AW-1:0]  reg_addr,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  reg_rvalid,
  // host table access
  input wire logic                  ev_host_access,
  input wire logic [9:0]            ev_host_bucket,
  // packets
  input wire logic                  pkt_valid,
  input wire logic                  pkt_unknown_vid,
  input wire logic                  pkt_unknown_uc,
  input wire logic                  pkt_unknown_mc,
  input wire logic                  fwd_valid,
  input wire logic                  fwd_special,
  input wire lkidx_pkg::lkidx_port_map_t fwd_port_map,
  input wire lkidx_pkg::lkidx_cat_t fwd_category
);
  import lkidx_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_vid; pkt_valid && pkt_unknown_vid; endsequence
  sequence s_uc; pkt_valid && !pkt_unknown_vid && pkt_unknown_uc; endsequence
  sequence s_mc; pkt_valid && !pkt_unknown_vid && !pkt_unknown_uc && pkt_unknown_mc; endsequence
  sequence s_host_rd;
    ev_host_access ##1 !ev_host_access ##1 (reg_rd && reg_addr == 12'h31B && !ev_host_access);
  endsequence
  fwd_pulse_a: assert property (pkt_valid |=> fwd_valid) else $error("no forward result");
  fwd_idle_a: assert property (!pkt_valid |=> !fwd_valid && fwd_category == LKIDX_CAT_NONE)
    else $error("forward result without packet");
  vid_first_a: assert property (s_vid |=> fwd_category == LKIDX_CAT_VID)
    else $error("vlan category lost");
  uc_second_a: assert property (s_uc |=> fwd_category == LKIDX_CAT_UC)
    else $error("unicast category lost");
  mc_third_a: assert property (s_mc |=> fwd_category == LKIDX_CAT_MC)
    else $error("multicast category lost");
  map_gated_a: assert property (!fwd_special |-> fwd_port_map == 5'h00)
    else $error("port map without special forward");
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  idx0_width_a: assert property (reg_rd && reg_addr == 12'h316 |=> reg_rdata[7:4] == 4'h0)
    else $error("index 0 reserved bits set");
  idx12_width_a: assert property (reg_rd && (reg_addr == 12'h318 || reg_addr == 12'h31A)
    |=> reg_rdata[7:2] == 6'h00) else $error("index 1 or 2 reserved bits set");
  host_capture_a: assert property (s_host_rd |=>
    {2'b00, reg_rdata} == ($past(ev_host_bucket, 3) & 10'h0FF)) else $error("host index wrong");
endmodule : lkidx_lookup_status_sva
bind lkidx_lookup_status lkidx_lookup_status_sva u_sva (.clk_sys, .rst_n, .reg_rd, .reg_addr,
  .reg_rdata, .reg_rvalid, .ev_host_access, .ev_host_bucket, .pkt_valid, .pkt_unknown_vid,
  .pkt_unknown_uc, .pkt_unknown_mc, .fwd_valid, .fwd_special, .fwd_port_map, .fwd_category);
`default_nettype wire

//--- test_lookup_index_unknown_fwd.sv
// self-checking bench for the lookup index and unknown-forward block
`default_nettype none
module test_lookup_index_unknown_fwd import lkidx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, lue_int;
  logic [11:0]     reg_addr, ev_entry_addr;
  logic [7:0]      reg_wdata, reg_rdata;
  logic            ev_static_wr_ok, ev_static_wr_fail, ev_learn_fail, ev_host_access;
  logic [2:0]      ev_static_prior_cnt, ev_learn_static_cnt;
  logic [9:0]      ev_fail_bucket, ev_learn_bucket, ev_host_bucket;
  logic            pkt_valid, pkt_unknown_vid, pkt_unknown_uc, pkt_unknown_mc;
  logic            fwd_valid, fwd_special;
  lkidx_port_map_t fwd_port_map;
  lkidx_cat_t      fwd_category;
  int              bad_count = 0;
  int              n_compared = 0;
  int              seed = 32'hFD3074B6;
  logic [7:0]      q_rd[$];
  logic [7:0]      q_fw[$];
  logic            en[3];
  lkidx_port_map_t pm[3];

  lkidx_lookup_status uut (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .ev_static_wr_ok, .ev_static_prior_cnt, .ev_entry_addr, .ev_static_wr_fail,
    .ev_fail_bucket, .ev_learn_fail, .ev_learn_static_cnt, .ev_learn_bucket, .ev_host_access,
    .ev_host_bucket, .pkt_valid, .pkt_unknown_vid, .pkt_unknown_uc, .pkt_unknown_mc,
    .fwd_valid, .fwd_special, .fwd_port_map, .fwd_category, .lue_int);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic bad(input string m);
    bad_count++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  task automatic cmp_rd;
    n_compared++;
    if (q_rd.size() == 0) bad("read data not expected");
    else if (reg_rdata !== q_rd.pop_front()) bad("read data differs");
  endtask : cmp_rd
  task automatic cmp_fwd;
    n_compared++;
    if (q_fw.size() == 0) bad("forward result not expected");
    else if ({fwd_special, fwd_category, fwd_port_map} !== q_fw.pop_front()) bad("forward differs");
  endtask : cmp_fwd
  task automatic cmp_int(input logic e);
    @(negedge clk_sys);
    n_compared++;
    if (lue_int !== e) bad("summary flag differs");
  endtask : cmp_int
  // results are settled by the falling edge
  always @(negedge clk_sys) begin
    if (reg_rvalid === 1'b1) cmp_rd();
    if (fwd_valid === 1'b1) cmp_fwd();
  end
  // control index: 0 unicast, 1 multicast, 2 unknown VLAN
  function automatic logic [7:0] exp_fwd(input logic [2:0] f);
    int         i;
    lkidx_cat_t c;
    c = f[2] ? LKIDX_CAT_VID : f[1] ? LKIDX_CAT_UC : f[0] ? LKIDX_CAT_MC : LKIDX_CAT_NONE;
    i = f[2] ? 2 : f[1] ? 0 : 1;
    if (c == LKIDX_CAT_NONE || !en[i]) return {1'b0, c, 5'h00};
    return {1'b1, c, pm[i]};
  endfunction : exp_fwd

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q_rd.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic rd16(input logic [11:0] a, input logic [15:0] e);
    rd(a + 12'h001, e[7:0]);
    rd(a, e[15:8]);
  endtask : rd16
  task automatic ev(input int k, input logic [2:0] c, input logic [11:0] a);
    @(posedge clk_sys);
    ev_entry_addr <= a;
    ev_fail_bucket <= a[9:0];
    ev_learn_bucket <= a[9:0];
    ev_host_bucket <= a[9:0];
    ev_static_prior_cnt <= c;
    ev_learn_static_cnt <= c;
    {ev_static_wr_ok, ev_static_wr_fail, ev_learn_fail, ev_host_access} <= 4'h8 >> k;
    @(posedge clk_sys);
    {ev_static_wr_ok, ev_static_wr_fail, ev_learn_fail, ev_host_access} <= 4'h0;
  endtask : ev
  task automatic pkt(input logic [2:0] f);
    @(posedge clk_sys);
    pkt_valid <= 1'b1;
    {pkt_unknown_vid, pkt_unknown_uc, pkt_unknown_mc} <= f;
    q_fw.push_back(exp_fwd(f));
    @(posedge clk_sys);
    pkt_valid <= 1'b0;
  endtask : pkt
  task automatic close_out;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial begin
    logic [11:0] a;
    logic [15:0] x;
    logic [7:0]  b;
    logic [7:0]  m;
    {reg_wr, reg_rd, reg_addr, reg_wdata, ev_entry_addr, ev_fail_bucket} = '0;
    {ev_static_wr_ok, ev_static_wr_fail, ev_learn_fail, ev_host_access} = '0;
    {ev_static_prior_cnt, ev_learn_static_cnt, ev_learn_bucket, ev_host_bucket} = '0;
    {pkt_valid, pkt_unknown_vid, pkt_unknown_uc, pkt_unknown_mc} = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 12'h314; i <= 12'h32B; i++) rd(12'(i), (i == 12'h315) ? 8'h07 : 8'h00);
    cmp_int(1'b0);
    $display("test reset values done");
    x = 16'h0000;
    for (int c = 0; c <= 4; c++) begin
      a = 12'($random(seed));
      ev(0, 3'(c), a);
      if (c == 2 || c == 3) x = {4'h0, a};
      rd16(12'h316, x);
      rd(12'h314, (c >= 2) ? 8'h02 : 8'h00);
    end
    a = 12'($random(seed));
    x = {6'h00, a[9:0]};
    ev(1, 3'h4, a);
    rd16(12'h316, x);
    rd(12'h314, 8'h03);
    wr(12'h315, 8'h06);
    cmp_int(1'b1);
    wr(12'h314, 8'h01);
    cmp_int(1'b0);
    $display("test write index done");
    a = 12'($random(seed));
    ev(2, 3'h3, a);
    rd16(12'h318, 16'h0000);
    ev(2, 3'h4, a);
    rd16(12'h318, {6'h00, a[9:0]});
    rd(12'h314, 8'h06);
    for (int i = 0; i < 2; i++) begin
      a = 12'($random(seed));
      ev(3, 3'h0, a);
      rd16(12'h31A, {6'h00, a[9:0]});
    end
    rd16(12'h316, x);
    $display("test learn and host index done");
    for (int r = 0; r < 3; r++) begin
      b = 8'($random(seed));
      m = 8'($random(seed));
      wr(12'h320 + 12'(4 * r), b);
      wr(12'h323 + 12'(4 * r), m);
      pm[r] = {m[6], m[3:0]};
      rd(12'h320 + 12'(4 * r), b & 8'h80);
      rd(12'h323 + 12'(4 * r), m & 8'h4F);
    end
    for (int e = 0; e < 8; e++) begin
      for (int r = 0; r < 3; r++) begin
        wr(12'h320 + 12'(4 * r), {e[r], 7'($random(seed))});
        en[r] = e[r];
      end
      for (int f = 0; f < 8; f++) pkt(3'(f));
    end
    $display("test unknown forwarding done");
    for (int i = 0; i < 20 && q_rd.size() + q_fw.size() > 0; i++) @(posedge clk_sys);
    if (q_rd.size() + q_fw.size() > 0) bad("results missing");
    close_out();
  end
endmodule : test_lookup_index_unknown_fwd
`default_nettype wire
